// File: logic/bftsu_pkg.sv
// bit-field test/set unit: shared constants, register map and types
// assumes a 16-bit data path and a 32-bit APB register bus
`default_nettype none
package bftsu_pkg;
  // ----------------------------------------------------------------
  // data and field widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;
  localparam int FIELD_W = 5;
  localparam int SHORT_W = 6;
  localparam int CNT_W = 4;
  // ----------------------------------------------------------------
  // APB register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_DEST = 8'h08;
  localparam logic [7:0] OFS_ADDR = 8'h0C;
  localparam logic [7:0] OFS_OPERAND = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_INFO = 8'h18;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_START = 0;
  localparam int CTRL_OP = 1;
  localparam int CTRL_MODE_LO = 2;
  localparam int CTRL_LIMIT = 6;
  localparam int DEST_SHORT_LO = 8;
  localparam int STAT_CARRY = 0;
  localparam int STAT_LIMIT = 6;
  localparam int INFO_BUSY = 0;
  localparam int INFO_DONE = 1;
  localparam int INFO_REFUSED = 2;
  localparam int INFO_CYC_LO = 4;
  localparam int INFO_WORDS_LO = 8;
  // ----------------------------------------------------------------
  // register destination codes and peripheral region
  // ----------------------------------------------------------------
  localparam logic [FIELD_W-1:0] FIELD_STATUS_WORD = 5'h19;
  localparam logic [FIELD_W-1:0] FIELD_HW_STACK = 5'h1F;
  localparam logic [ADDR_W-1:0] IO_BASE = 16'hFFC0;
  localparam logic [DATA_W-1:0] STATUS_RESET = 16'h0000;
  // ----------------------------------------------------------------
  // cycle and word costs
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] COST_SHORT = 4'h4;
  localparam logic [CNT_W-1:0] COST_LONG = 4'h6;
  localparam logic [1:0] WORDS_SHORT = 2'h2;
  localparam logic [1:0] WORDS_LONG = 2'h3;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_REG, MODE_ABS_SHORT, MODE_IO_SHORT, MODE_IDX_R2, MODE_IDX_SP, MODE_ABS_LONG
  } bftsu_mode_e;
  typedef enum logic {OP_TEST_SET, OP_TEST_HIGH} bftsu_op_e;
endpackage : bftsu_pkg
`default_nettype wire

// File: logic/bftsu_calc_if.sv
// bit-field test/set unit: link between sequencer and field calculator
// assumes both ends sit in the same clock domain
`default_nettype none
interface bftsu_calc_if;
  import bftsu_pkg::*;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] mask;
  bftsu_op_e op;
  logic all_ones;
  logic [DATA_W-1:0] result;
  modport seq (output operand, output mask, output op, input all_ones, input result);
  modport calc (input operand, input mask, input op, output all_ones, output result);
endinterface : bftsu_calc_if
`default_nettype wire

// File: logic/bftsu_field_calc.sv
// bit-field test/set unit: combinational mask test and set
// assumes operand and mask are stable while the sequencer samples
`default_nettype none
module bftsu_field_calc (
  bftsu_calc_if.calc cif // operand, mask and results
);
  import bftsu_pkg::*;
  // ----------------------------------------------------------------
  // test and merge
  // ----------------------------------------------------------------
  // an all-zero mask tests true and merges nothing
  assign cif.all_ones = ((cif.operand & cif.mask) == cif.mask);
  // only the set form changes data; the test form passes it through
  assign cif.result = (cif.op == OP_TEST_SET) ? (cif.operand | cif.mask) : cif.operand;
endmodule : bftsu_field_calc
`default_nettype wire

// File: logic/bftsu_unit.sv
// bit-field test/set unit: APB slave, sequencer and data memory master
// assumes the memory port and APB run on i_ref_clk; memory answers with ack
`default_nettype none
// Notes on behaviour
// - test-and-set: carry when all masked bits one
// - then force masked bits one, write back
// - high-test: same carry, destination unchanged
// - high-test makes exactly two destination accesses
// - zero mask: destination unchanged, carry set
// - limit flag set on 36-bit limiting
// - status destination: mask only, no flag rules
// - costs 4/2, 6/2 indexed, 6/3 long
// - any register field except hardware stack
// - absolute short carries 6-bit data address
// - io short selects peripheral region word
// - test-and-set: one read then one write
module bftsu_unit (
  input wire logic i_ref_clk, // core clock, 40 MHz
  input wire logic i_rst_n, // async reset, active low
  input wire logic i_clk_en, // freezes all state when low
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB enable
  input wire logic i_pwrite, // APB direction
  input wire logic [7:0] i_paddr, // APB byte address
  input wire logic [31:0] i_pwdata, // APB write data
  output logic [31:0] o_prdata, // APB read data
  output logic o_pready, // APB ready
  output logic o_pslverr, // APB error on unmapped address
  output logic o_mem_req, // memory access request
  output logic o_mem_we, // memory write when high
  output logic [bftsu_pkg::ADDR_W-1:0] o_mem_addr, // memory word address
  output logic [bftsu_pkg::DATA_W-1:0] o_mem_wdata, // memory write data
  input wire logic [bftsu_pkg::DATA_W-1:0] i_mem_rdata, // memory read data
  input wire logic i_mem_ack, // memory access done
  output logic o_busy // instruction in flight
);
  import bftsu_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_RD1, ST_RD2, ST_WR, ST_HOLD} bftsu_state_e;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  // release is synchronised so every flop leaves reset on the same edge
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bftsu_state_e state;
  bftsu_state_e next_state;
  logic [DATA_W-1:0] mask_q;
  logic [DATA_W-1:0] dest_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] operand_q;
  logic [DATA_W-1:0] status_word;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cost_q;
  logic [1:0] words_q;
  logic [2:0] ctrl_mode_q;
  logic op_q;
  logic limit_q;
  logic carry_q;
  logic done_q;
  logic refused_q;
  logic [1:0] acc_cnt;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire apb_acc = i_psel & i_penable & i_clk_en;
  wire apb_wr = apb_acc & i_pwrite;
  wire sel_ctrl = (i_paddr == OFS_CTRL);
  wire sel_mask = (i_paddr == OFS_MASK);
  wire sel_dest = (i_paddr == OFS_DEST);
  wire sel_addr = (i_paddr == OFS_ADDR);
  wire sel_oper = (i_paddr == OFS_OPERAND);
  wire sel_stat = (i_paddr == OFS_STATUS);
  wire sel_info = (i_paddr == OFS_INFO);
  wire mapped = sel_ctrl | sel_mask | sel_dest | sel_addr | sel_oper | sel_stat | sel_info;
  wire busy = (state != ST_IDLE);
  // setup registers are locked while busy so the operation sees stable inputs
  wire wr_setup = apb_wr & ~busy;
  wire start = wr_setup & sel_ctrl & i_pwdata[CTRL_START];
  wire [2:0] wr_mode = i_pwdata[CTRL_MODE_LO +: 3];
  wire [FIELD_W-1:0] field = dest_q[FIELD_W-1:0];
  wire [SHORT_W-1:0] short_ofs = dest_q[DEST_SHORT_LO +: SHORT_W];
  wire is_reg = (ctrl_mode_q == MODE_REG);
  wire to_status = is_reg & (field == FIELD_STATUS_WORD);
  // the hardware stack is a legal field code but not a legal operand
  wire start_hws = start & (wr_mode == MODE_REG) & (dest_q[FIELD_W-1:0] == FIELD_HW_STACK);
  wire start_ok = start & ~start_hws;

  // ----------------------------------------------------------------
  // cost and address selection
  // ----------------------------------------------------------------
  function automatic logic is_long(input logic [2:0] m);
    is_long = (m == MODE_IDX_R2) | (m == MODE_IDX_SP) | (m == MODE_ABS_LONG);
  endfunction : is_long

  wire [CNT_W-1:0] start_cost = is_long(wr_mode) ? COST_LONG : COST_SHORT;
  wire [1:0] start_words = (wr_mode == MODE_ABS_LONG) ? WORDS_LONG : WORDS_SHORT;
  wire [ADDR_W-1:0] ofs_ext = {{(ADDR_W-SHORT_W){1'b0}}, short_ofs};
  wire [ADDR_W-1:0] ea_abs = ofs_ext;
  wire [ADDR_W-1:0] ea_io = IO_BASE | ofs_ext;
  wire [ADDR_W-1:0] ea_r2 = addr_q + ofs_ext;
  wire [ADDR_W-1:0] ea_sp = addr_q - ofs_ext;
  wire [ADDR_W-1:0] ea_sel = (wr_mode == MODE_ABS_SHORT) ? ea_abs :
                             (wr_mode == MODE_IO_SHORT) ? ea_io :
                             (wr_mode == MODE_IDX_R2) ? ea_r2 :
                             (wr_mode == MODE_IDX_SP) ? ea_sp : addr_q;

  // ----------------------------------------------------------------
  // access path
  // ----------------------------------------------------------------
  // register destinations complete an access in one cycle
  wire in_access = (state == ST_RD1) | (state == ST_RD2) | (state == ST_WR);
  wire acc_ack = in_access & (is_reg | i_mem_ack);
  wire [DATA_W-1:0] reg_rd = to_status ? status_word : operand_q;
  wire [DATA_W-1:0] acc_rdata = is_reg ? reg_rd : i_mem_rdata;
  wire cost_met = (cnt_q >= cost_q - 4'h1);
  wire commit = (state == ST_HOLD) & cost_met & i_clk_en;
  wire rd1_done = (state == ST_RD1) & acc_ack & i_clk_en;
  wire wr_done = (state == ST_WR) & acc_ack & i_clk_en;

  bftsu_calc_if cif ();
  assign cif.operand = acc_rdata;
  assign cif.mask = mask_q;
  assign cif.op = bftsu_op_e'(op_q);

  bftsu_field_calc u_calc (
    .cif(cif.calc)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // read first, then write for set or re-read for test
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_ok) begin
          next_state = ST_RD1;
        end
      end
      ST_RD1: begin
        if (acc_ack) begin
          next_state = (op_q == OP_TEST_SET) ? ST_WR : ST_RD2;
        end
      end
      ST_RD2: begin
        if (acc_ack) begin
          next_state = ST_HOLD;
        end
      end
      ST_WR: begin
        if (acc_ack) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (cost_met) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else if (i_clk_en) begin
      state <= next_state;
    end
  end

  // cycle counter; a slow memory stretches the cost, never shortens it
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (i_clk_en) begin
      cnt_q <= (start_ok | ~busy) ? '0 : cnt_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // operation setup registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= '0;
      dest_q <= '0;
      addr_q <= '0;
      op_q <= 1'b0;
      ctrl_mode_q <= '0;
      limit_q <= 1'b0;
    end else if (wr_setup) begin
      if (sel_mask) begin
        mask_q <= i_pwdata[DATA_W-1:0];
      end else if (sel_dest) begin
        dest_q <= i_pwdata[DATA_W-1:0];
      end else if (sel_addr) begin
        addr_q <= i_pwdata[ADDR_W-1:0];
      end else if (sel_ctrl) begin
        op_q <= i_pwdata[CTRL_OP];
        ctrl_mode_q <= wr_mode;
        limit_q <= i_pwdata[CTRL_LIMIT];
      end
    end
  end

  // launch values and results captured on the first read
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_mem_addr <= '0;
      o_mem_wdata <= '0;
      carry_q <= 1'b0;
      cost_q <= COST_SHORT;
      words_q <= WORDS_SHORT;
    end else if (start_ok) begin
      o_mem_addr <= ea_sel;
      cost_q <= start_cost;
      words_q <= start_words;
    end else if (rd1_done) begin
      carry_q <= cif.all_ones;
      o_mem_wdata <= cif.result;
    end
  end

  // ----------------------------------------------------------------
  // destination registers and flags
  // ----------------------------------------------------------------
  // engine writes take priority; software cannot write them while busy
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      operand_q <= '0;
      status_word <= STATUS_RESET;
    end else if (wr_done & is_reg) begin
      if (to_status) begin
        status_word <= o_mem_wdata;
      end else begin
        operand_q <= o_mem_wdata;
      end
    end else if (commit & ~to_status) begin
      status_word[STAT_CARRY] <= carry_q;
      if (limit_q) begin
        status_word[STAT_LIMIT] <= 1'b1;
      end
    end else if (wr_setup & sel_oper) begin
      operand_q <= i_pwdata[DATA_W-1:0];
    end else if (wr_setup & sel_stat) begin
      status_word <= i_pwdata[DATA_W-1:0];
    end
  end

  // done and refused are sticky; a new completion beats a clear
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
      refused_q <= 1'b0;
    end else if (i_clk_en) begin
      if (commit | start_hws) begin
        done_q <= 1'b1;
      end else if (apb_wr & sel_info & i_pwdata[INFO_DONE]) begin
        done_q <= 1'b0;
      end
      if (start_hws) begin
        refused_q <= 1'b1;
      end else if (start_ok) begin
        refused_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // memory is only touched for memory destinations
  assign o_mem_req = in_access & ~is_reg;
  assign o_mem_we = (state == ST_WR) & ~is_reg;
  assign o_busy = busy;
  assign o_pready = i_clk_en;
  assign o_pslverr = i_psel & i_penable & ~mapped;

  // read data is registered to keep the bus output glitch free
  wire [31:0] info_word = {22'h0, words_q, cnt_q, 1'b0, refused_q, done_q, busy};
  wire [31:0] rd_mux = sel_ctrl ? {25'h0, limit_q, 1'b0, ctrl_mode_q, op_q, 1'b0} :
                       sel_mask ? {16'h0, mask_q} :
                       sel_dest ? {16'h0, dest_q} :
                       sel_addr ? {16'h0, addr_q} :
                       sel_oper ? {16'h0, operand_q} :
                       sel_stat ? {16'h0, status_word} :
                       sel_info ? info_word : 32'h0;
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_prdata <= '0;
    end else if (i_clk_en & i_psel & ~i_penable & ~i_pwrite) begin
      o_prdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // assertion helpers
  // ----------------------------------------------------------------
  // counts completed destination accesses of the current operation
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_cnt <= '0;
    end else if (i_clk_en) begin
      if (start_ok) begin
        acc_cnt <= '0;
      end else if (acc_ack) begin
        acc_cnt <= acc_cnt + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_carry_commit: assert property (commit & ~to_status |=> status_word[STAT_CARRY] == $past(carry_q))
    else $error("carry not taken from mask test");
  a_set_merge: assert property (o_mem_we |-> (o_mem_wdata & mask_q) == mask_q)
    else $error("masked bits not forced to one");
  a_test_no_write: assert property (op_q == OP_TEST_HIGH && busy |-> !o_mem_we && state != ST_WR)
    else $error("high-test wrote its destination");
  a_two_access: assert property (commit |-> acc_cnt == 2'h2)
    else $error("destination access count not two");
  a_zero_mask: assert property (commit & ~to_status & (mask_q == '0) |=> status_word[STAT_CARRY])
    else $error("zero mask did not set carry");
  a_limit_flag: assert property (commit & ~to_status & limit_q |=> status_word[STAT_LIMIT])
    else $error("limit flag not set");
  a_status_dest: assert property (commit & to_status |=> $stable(status_word))
    else $error("status destination took flag rules");
  a_cycle_cost: assert property (start_ok |=> (busy [*3]) ##1 (busy || cost_q == COST_SHORT))
    else $error("operation shorter than its cost");
  a_long_words: assert property (start_ok & (wr_mode == MODE_ABS_LONG) |=> words_q == WORDS_LONG)
    else $error("long address word count wrong");
  a_hws_refused: assert property (start_hws |=> !busy && refused_q && done_q)
    else $error("hardware stack operand accepted");
  a_short_addr: assert property (o_mem_req && ctrl_mode_q == MODE_ABS_SHORT |-> o_mem_addr[ADDR_W-1:SHORT_W] == '0)
    else $error("absolute short address wider than 6 bits");
  a_io_addr: assert property (o_mem_req && ctrl_mode_q == MODE_IO_SHORT |-> (o_mem_addr & IO_BASE) == IO_BASE)
    else $error("io short address outside peripheral region");
  a_rmw_order: assert property (rd1_done && op_q == OP_TEST_SET |=> state == ST_WR)
    else $error("write did not follow read");

  c_set_mem: cover property (wr_done & ~is_reg);
  c_test_reg: cover property (commit & is_reg & (op_q == OP_TEST_HIGH));
  c_status_set: cover property (wr_done & to_status);
  c_refused: cover property (start_hws);
endmodule : bftsu_unit
`default_nettype wire

// File: sim/bftsu_mem_model.sv
// bftsu memory model: data memory on the far side of the unit's access port
// assumes one access at a time; ack can be held off by i_delay cycles
`default_nettype none
module bftsu_mem_model (
  input wire logic i_clk, // core clock
  input wire logic i_rst_n, // reset, active low
  input wire logic [1:0] i_delay, // wait cycles before ack
  input wire logic i_req, // access request
  input wire logic i_we, // write when high
  input wire logic [15:0] i_addr, // word address
  input wire logic [15:0] i_wdata, // write data
  output logic [15:0] o_rdata, // read data
  output logic o_ack // access done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:65535];
  logic [15:0] last;
  logic [1:0] wait_cnt;
  int n_rd;
  int n_wr;
  // idle data is the inverse of the last word so a stale sample never matches
  assign o_ack = i_req && (wait_cnt >= i_delay);
  assign o_rdata = (o_ack && !i_we) ? mem[i_addr] : ~last;
  // plain always: the bench preloads mem from outside
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_cnt <= 2'h0;
      last <= 16'h0;
    end else if (o_ack) begin
      wait_cnt <= 2'h0;
      if (i_we) begin
        mem[i_addr] <= i_wdata;
        n_wr <= n_wr + 1;
      end else begin
        last <= mem[i_addr];
        n_rd <= n_rd + 1;
      end
    end else if (i_req) begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule : bftsu_mem_model
`default_nettype wire

// File: sim/tb_top.sv
// bftsu testbench: drives the unit over APB, memory answered by the model
// assumes one 40 MHz clock for unit, bus and memory
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bftsu_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, serr, req, we, ack, busy;
  logic [15:0] maddr, wdata, mrdata, st, inf;
  logic [1:0] delay = 2'h0;
  int err_total = 0, num_checks = 0, cyc, r0, w0;
  localparam logic [15:0] EA [1:5] = '{16'h0015, 16'hFFD5, 16'h1015, 16'h0FEB, 16'h1000};
  always #12.5 clk = ~clk;
  bftsu_unit u_bftsu_unit (.i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en(clk_en), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_mem_req(req), .o_mem_we(we), .o_mem_addr(maddr),
    .o_mem_wdata(wdata), .i_mem_rdata(mrdata), .i_mem_ack(ack), .o_busy(busy));
  bftsu_mem_model u_bftsu_mem_model (.i_clk(clk), .i_rst_n(rst_n), .i_delay(delay), .i_req(req),
    .i_we(we), .i_addr(maddr), .i_wdata(wdata), .o_rdata(mrdata), .o_ack(ack));
  // ----------------------------------------------------------------
  // bus and run helpers
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  // one transfer; the idle edge first keeps two tasks from driving in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      err_total++;
      end_of_test();
    end
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  // loads operands, starts, counts busy cycles, then reads status and info
  task automatic run_op(input logic op, input logic [2:0] md, input logic [4:0] fld,
    input logic [15:0] msk, input logic lim, input logic [15:0] st0);
    apb(1'b1, OFS_STATUS, 32'(st0));
    apb(1'b1, OFS_MASK, 32'(msk));
    apb(1'b1, OFS_DEST, {18'h0, 6'h15, 3'h0, fld});
    apb(1'b1, OFS_ADDR, 32'h1000);
    apb(1'b1, OFS_OPERAND, 32'h1234);
    r0 = u_bftsu_mem_model.n_rd;
    w0 = u_bftsu_mem_model.n_wr;
    apb(1'b1, OFS_CTRL, 32'({lim, 1'b0, md, op, 1'b1}));
    for (cyc = 0; cyc < 40; cyc++) begin
      #1;
      if (busy !== 1'b1) break;
      @(posedge clk);
    end
    if (cyc == 40) begin
      err_total++;
      end_of_test();
    end
    apb(1'b0, OFS_STATUS, 32'h0);
    st = rd[15:0];
    apb(1'b0, OFS_INFO, 32'h0);
    inf = rd[15:0];
  endtask : run_op
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_modes;
    for (int m = 1; m <= 5; m++) begin
      u_bftsu_mem_model.mem[EA[m]] = 16'h8921;
      run_op(OP_TEST_SET, 3'(m), 5'h00, 16'hF400, 1'b0, 16'h0000);
      `CHK(u_bftsu_mem_model.mem[EA[m]], 16'hFD21)
      `CHK(st[STAT_CARRY], 1'b0)
      `CHK(u_bftsu_mem_model.n_rd - r0, 1)
      `CHK(u_bftsu_mem_model.n_wr - w0, 1)
      `CHK(cyc, (m < 3) ? 4 : 6)
      `CHK(inf[9:8], (m == 5) ? 2'h3 : 2'h2)
      run_op(OP_TEST_SET, 3'(m), 5'h00, 16'hF400, 1'b0, 16'h0000);
      `CHK(st[STAT_CARRY], 1'b1)
    end
  endtask : t_modes
  task automatic t_high;
    u_bftsu_mem_model.mem[16'hFFD5] = 16'h0FF0;
    run_op(OP_TEST_HIGH, 3'h2, 5'h00, 16'h0310, 1'b1, 16'h0000);
    `CHK(st[STAT_CARRY], 1'b1)
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK(rd, 32'h0000004A)
    `CHK(st[STAT_LIMIT], 1'b1)
    `CHK(u_bftsu_mem_model.n_rd - r0, 2)
    `CHK(u_bftsu_mem_model.n_wr - w0, 0)
    run_op(OP_TEST_HIGH, 3'h2, 5'h00, 16'h0311, 1'b0, 16'h0000);
    `CHK(st[STAT_CARRY], 1'b0)
    `CHK(st[STAT_LIMIT], 1'b0)
    `CHK(u_bftsu_mem_model.mem[16'hFFD5], 16'h0FF0)
  endtask : t_high
  // register destination: zero mask first, then a mask with unset bits
  task automatic t_reg;
    run_op(OP_TEST_SET, 3'h0, 5'h05, 16'h0000, 1'b0, 16'h0000);
    `CHK(st[STAT_CARRY], 1'b1)
    apb(1'b0, OFS_OPERAND, 32'h0);
    `CHK(rd[15:0], 16'h1234)
    run_op(OP_TEST_SET, 3'h0, 5'h05, 16'h00F0, 1'b0, 16'h0000);
    `CHK(st[STAT_CARRY], 1'b0)
    `CHK(cyc, 4)
    `CHK(u_bftsu_mem_model.n_rd - r0, 0)
    apb(1'b0, OFS_OPERAND, 32'h0);
    `CHK(rd[15:0], 16'h12F4)
  endtask : t_reg
  // status word as destination: the normal flag rules must not apply
  task automatic t_status;
    run_op(OP_TEST_SET, 3'h0, FIELD_STATUS_WORD, 16'h0100, 1'b1, 16'h0000);
    `CHK(st, 16'h0100)
    run_op(OP_TEST_HIGH, 3'h0, FIELD_STATUS_WORD, 16'h0002, 1'b1, 16'h0001);
    `CHK(st, 16'h0001)
  endtask : t_status
  task automatic t_stack;
    run_op(OP_TEST_SET, 3'h0, FIELD_HW_STACK, 16'h0001, 1'b0, 16'h0000);
    `CHK(inf[INFO_REFUSED], 1'b1)
    `CHK(cyc, 0)
    run_op(OP_TEST_SET, 3'h0, 5'h1E, 16'h0001, 1'b0, 16'h0000);
    `CHK(inf[INFO_REFUSED], 1'b0)
  endtask : t_stack
  // slow memory stretches the run; unmapped read and frozen clock enable
  task automatic t_bus;
    delay <= 2'h2;
    u_bftsu_mem_model.mem[16'h0015] = 16'h0000;
    run_op(OP_TEST_SET, 3'h1, 5'h00, 16'h000F, 1'b0, 16'h0000);
    `CHK(u_bftsu_mem_model.mem[16'h0015], 16'h000F)
    `CHK(cyc > 4, 1'b1)
    delay <= 2'h0;
    apb(1'b0, 8'h40, 32'h0);
    `CHK(serr, 1'b1)
    apb(1'b0, OFS_MASK, 32'h0);
    `CHK(serr, 1'b0)
    @(posedge clk);
    clk_en <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(pready, 1'b0)
    clk_en <= 1'b1;
  endtask : t_bus
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_modes();
    t_high();
    t_reg();
    t_status();
    t_stack();
    t_bus();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
